// file: sio_defines.vh
// constants for the spindle index orientation block
`ifndef SIO_DEFINES_VH
`define SIO_DEFINES_VH
`define SIO_CLK_HZ 10000000
`define SIO_QUAL_TIME_MS 400
`define SIO_QUAL_CYCLES ((`SIO_QUAL_TIME_MS * (`SIO_CLK_HZ / 1000)))
`define SIO_INDEX_MIN_US 10
`define SIO_INDEX_MIN_CYCLES ((`SIO_INDEX_MIN_US * `SIO_CLK_HZ) / 1000000)
`define SIO_POS_W 32
`define SIO_MODE_QUAD 1'b0
`define SIO_MODE_PDIR 1'b1
`define SIO_RATE_W 16
`define SIO_RATE_GATE_CYCLES 10000000
`endif

// file: sio_sync2.v
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module sio_sync2 #(
    parameter W = 3
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // pins in, synchronised out
    input wire [W-1:0] pin_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else
        begin
            meta_q <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule

// file: sio_encoder_count.v
// quadrature or pulse-plus-direction position counter
`timescale 1ns/1ps
`include "sio_defines.vh"
module sio_encoder_count #(
    parameter POS_W = `SIO_POS_W
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // synchronised encoder channels
    input wire chan_a,
    input wire chan_b,
    input wire mode_pdir,
    // count step out
    output reg step_up,
    output reg step_dn
);
    reg a_q;
    reg b_q;
    reg edge_a;
    reg edge_b;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end
        else
        begin
            a_q <= chan_a;
            b_q <= chan_b;
        end
    end

    // pdir: a is pulse, b is direction; two counts per line
    always @*
    begin
        edge_a = chan_a ^ a_q;
        edge_b = chan_b ^ b_q;
        step_up = 1'b0;
        step_dn = 1'b0;
        if (mode_pdir == `SIO_MODE_PDIR)
        begin
            step_up = edge_a & ~chan_b;
            step_dn = edge_a & chan_b;
        end
        else if (edge_a ^ edge_b)
        begin
            // four counts per line
            step_up = (edge_a & (chan_a ^ chan_b)) | (edge_b & ~(chan_a ^ chan_b));
            step_dn = ~((edge_a & (chan_a ^ chan_b)) | (edge_b & ~(chan_a ^ chan_b)));
        end
    end
endmodule

// file: sio_orient.v
// spindle index orientation and zero-speed position lock
// How it works
// - with the index gate off, orientation and the index rate monitor stop.
// - with the index gate off, a non-zero lock gain still locks at an arbitrary position.
// - the rising edge of the index input is the absolute position reference.
// - the home offset is added to the target once, at the start of each orientation.
// - later home offset changes leave the held position alone until the next orientation.
// - the sign of the home offset selects the seek direction.
// - four counts per line in quadrature, two in pulse-plus-direction, signed by direction.
// - an index pulse is only accepted while the index gate is on.
// - target writes while speed demand is above the standstill threshold do not affect motion.
// - while orienting every new target is followed.
// - the at-target flag is unfiltered and may toggle while settling.
// - orientation starts only after demand and feedback sit below threshold for 400 ms.
// - the last index accepted while the sequencer was idle, before qualification started, is the reference.
// - the lock is released by speed demand rising above the threshold or by a zero lock gain.
// - the at-target flag rises when each current target is reached.
`timescale 1ns/1ps
`include "sio_defines.vh"
module sio_orient #(
    parameter POS_W = `SIO_POS_W,
    parameter RATE_W = `SIO_RATE_W,
    parameter QUAL_CYCLES = `SIO_QUAL_CYCLES,
    parameter RATE_GATE_CYCLES = `SIO_RATE_GATE_CYCLES
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // encoder pins
    input wire enc_a,
    input wire enc_b,
    input wire index_input_terminal,
    // configuration
    input wire enc_mode_pdir,
    input wire index_gate_en,
    input wire [15:0] lock_gain,
    input wire signed [POS_W-1:0] home_offset,
    input wire signed [POS_W-1:0] target_pos,
    // speed comparisons from the drive
    input wire demand_below_thr,
    input wire feedback_below_thr,
    // position loop outputs
    output reg lock_active,
    output reg orient_active,
    output reg signed [POS_W-1:0] pos_error,
    output reg seek_reverse,
    output reg at_target_flag,
    output reg signed [POS_W-1:0] pos_count,
    output reg [RATE_W-1:0] index_rate_monitor
);
    // lock sequencer states
    localparam ST_IDLE = 2'd0;
    localparam ST_QUAL = 2'd1;
    localparam ST_LOCK = 2'd2;
    localparam [31:0] QUAL_LAST = QUAL_CYCLES - 1;
    localparam [31:0] IDX_MIN = (`SIO_INDEX_MIN_CYCLES < 1) ? 1 : `SIO_INDEX_MIN_CYCLES;
    localparam [31:0] GATE_LAST = RATE_GATE_CYCLES - 1;

    // synchronised pins and count steps
    wire [2:0] pins_s;
    wire step_up;
    wire step_dn;

    // lock sequencer
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [31:0] qual_cnt_q;

    // index marker capture and width check
    reg idx_q;
    reg [31:0] idx_wid_q;
    reg idx_seen_q;
    reg signed [POS_W-1:0] idx_pos_q;
    reg idx_accept;

    // position references
    reg signed [POS_W-1:0] ref_pos_q;
    reg signed [POS_W-1:0] hold_pos_q;
    reg signed [POS_W-1:0] goal;

    // index rate window
    reg [31:0] gate_cnt_q;
    reg [RATE_W-1:0] rate_acc_q;

    // lock qualifiers
    wire gain_on;
    wire below;

    // every pin passes two flops before any logic
    sio_sync2 #(.W(3)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in({index_input_terminal, enc_b, enc_a}),
        .sync_out(pins_s)
    );

    // one step pulse per counted channel edge
    sio_encoder_count #(.POS_W(POS_W)) u_count (
        .clk(clk),
        .rst_n(rst_n),
        .chan_a(pins_s[0]),
        .chan_b(pins_s[1]),
        .mode_pdir(enc_mode_pdir),
        .step_up(step_up),
        .step_dn(step_dn)
    );

    // a zero gain turns the position loop off
    assign gain_on = (lock_gain != 16'h0000);
    // both speed comparisons must report standstill
    assign below = demand_below_thr & feedback_below_thr;

    // position count, signed by direction
    always @(posedge clk)
    begin
        if (!rst_n)
            pos_count <= {POS_W{1'b0}};
        else if (step_up)
            pos_count <= pos_count + 1'b1;
        else if (step_dn)
            pos_count <= pos_count - 1'b1;
    end

    // index qualification: rising edge latched, width-checked for noise
    // accept pulses once, when the width reaches the minimum
    always @*
    begin
        idx_accept = pins_s[2] & idx_q & index_gate_en & (idx_wid_q == IDX_MIN - 1);
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            idx_q <= 1'b0;
            idx_wid_q <= 32'h0;
            idx_seen_q <= 1'b0;
            idx_pos_q <= {POS_W{1'b0}};
        end
        else
        begin
            idx_q <= pins_s[2];
            if (pins_s[2] & ~idx_q)
            begin
                idx_wid_q <= 32'h0;
                idx_pos_q <= pos_count;
            end
            else if (pins_s[2] && idx_wid_q != 32'hffffffff)
                idx_wid_q <= idx_wid_q + 32'h1;
            // only capture while the sequencer is idle, so the last one before qualification is kept
            if (idx_accept && state_q == ST_IDLE)
                idx_seen_q <= 1'b1;
            if (!index_gate_en)
                idx_seen_q <= 1'b0;
        end
    end

    // reference position held frozen from the last accepted index
    always @(posedge clk)
    begin
        if (!rst_n)
            ref_pos_q <= {POS_W{1'b0}};
        else if (idx_accept && state_q == ST_IDLE)
            ref_pos_q <= idx_pos_q;
    end

    // lock state machine
    // qualify for the full window before locking, so a speed
    // traverse through zero does not trigger a lock
    // feedback may exceed the threshold once locked
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (below && gain_on)
                    state_d = ST_QUAL;
            ST_QUAL:
                if (!below || !gain_on)
                    state_d = ST_IDLE;
                else if (qual_cnt_q == QUAL_LAST)
                    state_d = ST_LOCK;
            ST_LOCK:
                if (!demand_below_thr || !gain_on)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            qual_cnt_q <= 32'h0;
            hold_pos_q <= {POS_W{1'b0}};
            orient_active <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            // qualification time counted only inside qual
            if (state_q == ST_QUAL)
                qual_cnt_q <= qual_cnt_q + 32'h1;
            else
                qual_cnt_q <= 32'h0;
            // hold position taken once, at lock entry
            if (state_q == ST_QUAL && state_d == ST_LOCK)
            begin
                orient_active <= index_gate_en & idx_seen_q;
                if (index_gate_en && idx_seen_q)
                    hold_pos_q <= ref_pos_q + home_offset;
                else
                    hold_pos_q <= pos_count;
            end
            // gate off stops orientation even mid lock
            else if (state_d != ST_LOCK || !index_gate_en)
                orient_active <= 1'b0;
        end
    end

    // goal follows the target only while locked
    // without a marker reference the lock just holds its entry count
    always @*
    begin
        if (orient_active)
            goal = hold_pos_q + target_pos;
        else
            goal = hold_pos_q;
    end

    // outputs lag the sequencer by one clock
    // flag is a raw compare, it may chatter while settling
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            lock_active <= 1'b0;
            pos_error <= {POS_W{1'b0}};
            seek_reverse <= 1'b0;
            at_target_flag <= 1'b0;
        end
        else
        begin
            lock_active <= (state_q == ST_LOCK);
            if (state_q == ST_LOCK)
            begin
                pos_error <= goal - pos_count;
                // offset sign picks direction regardless of shortest path
                seek_reverse <= orient_active & home_offset[POS_W-1];
                at_target_flag <= (goal == pos_count);
            end
            else
            begin
                pos_error <= {POS_W{1'b0}};
                seek_reverse <= 1'b0;
                at_target_flag <= 1'b0;
            end
        end
    end

    // index rate: accepted markers per gate period
    // gate off clears the window and the reading
    always @(posedge clk)
    begin
        if (!rst_n || !index_gate_en)
        begin
            gate_cnt_q <= 32'h0;
            rate_acc_q <= {RATE_W{1'b0}};
            index_rate_monitor <= {RATE_W{1'b0}};
        end
        else if (gate_cnt_q == GATE_LAST)
        begin
            gate_cnt_q <= 32'h0;
            index_rate_monitor <= rate_acc_q + {{(RATE_W-1){1'b0}}, idx_accept};
            rate_acc_q <= {RATE_W{1'b0}};
        end
        else
        begin
            gate_cnt_q <= gate_cnt_q + 32'h1;
            if (idx_accept && rate_acc_q != {RATE_W{1'b1}})
                rate_acc_q <= rate_acc_q + 1'b1;
        end
    end
endmodule

// file: sio_enc_model.sv
// encoder model: quadrature or pulse+direction channels and index marker
`timescale 1ns/1ps
module sio_enc_model (
    // clock
    input wire clk,
    // encoder pins
    output logic enc_a,
    output logic enc_b,
    output logic idx
);
    logic [1:0] ph = 2'h0;
    initial {enc_a, enc_b, idx} = 3'h0;
    task automatic go(input int n, input bit dn, input bit pdir);
        repeat (n)
        begin
            if (pdir)
            begin
                enc_b = dn;
                repeat (4) @(posedge clk);
                #10 enc_a = ~enc_a;
            end
            else
            begin
                ph = dn ? ph - 2'h1 : ph + 2'h1;
                enc_a = ph[1];
                enc_b = ph[1] ^ ph[0];
            end
            repeat (4) @(posedge clk);
            #10;
        end
    endtask
    task automatic mark(input int w);
        idx = 1'b1;
        repeat (w) @(posedge clk);
        #10 idx = 1'b0;
        repeat (4) @(posedge clk);
        #10;
    endtask
endmodule

// file: sio_orient_chk.sv
// port assertions for the orientation block
`timescale 1ns/1ps
module sio_orient_chk #(
    parameter POS_W = 32,
    parameter QUAL_CYCLES = 4000000
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // inputs
    input wire enc_a,
    input wire enc_b,
    input wire enc_mode_pdir,
    input wire index_gate_en,
    input wire [15:0] lock_gain,
    input wire signed [POS_W-1:0] home_offset,
    input wire signed [POS_W-1:0] target_pos,
    input wire demand_below_thr,
    input wire feedback_below_thr,
    // outputs
    input wire lock_active,
    input wire orient_active,
    input wire signed [POS_W-1:0] pos_error,
    input wire seek_reverse,
    input wire at_target_flag,
    input wire signed [POS_W-1:0] pos_count
);
    logic [31:0] qcnt_q;
    logic [31:0] qcnt_d;
    // cycles spent qualifying for the lock
    always @*
        qcnt_d = (demand_below_thr && feedback_below_thr && lock_gain != 16'h0) ?
            qcnt_q + 32'h1 : 32'h0;
    always @(posedge clk)
        qcnt_q <= rst_n ? qcnt_d : 32'h0;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_still;
        $stable(enc_a) && $stable(enc_b) && $stable(enc_mode_pdir);
    endsequence
    sequence s_settled;
        (lock_active && pos_error == 0 && $stable(pos_count) && $stable(target_pos)) [*3];
    endsequence
    property p_idle; !lock_active && !$past(lock_active) |-> pos_error == 0 && !at_target_flag;
    endproperty
    a_idle: assert property (p_idle) else $error("output active while unlocked");
    property p_gate; !index_gate_en [*2] |-> !orient_active; endproperty
    a_gate: assert property (p_gate) else $error("orienting with gate off");
    property p_hold; lock_active && demand_below_thr && lock_gain != 16'h0 |=> lock_active;
    endproperty
    a_hold: assert property (p_hold) else $error("lock dropped early");
    property p_rel; lock_active && !demand_below_thr |-> ##[1:3] !lock_active; endproperty
    a_rel: assert property (p_rel) else $error("lock kept after demand rose");
    property p_gain0; lock_gain == 16'h0 |-> ##[1:3] !lock_active; endproperty
    a_gain0: assert property (p_gain0) else $error("lock with zero gain");
    property p_qual; $rose(lock_active) |-> qcnt_q >= QUAL_CYCLES; endproperty
    a_qual: assert property (p_qual) else $error("lock before qualification");
    property p_seek;
        orient_active && $past(orient_active) && $stable(home_offset) |->
            seek_reverse == home_offset[POS_W-1];
    endproperty
    a_seek: assert property (p_seek) else $error("seek direction wrong");
    property p_still; s_still [*7] |-> $stable(pos_count); endproperty
    a_still: assert property (p_still) else $error("count moved without pins");
    property p_settle; s_settled |-> at_target_flag; endproperty
    a_settle: assert property (p_settle) else $error("flag low at target");
endmodule
bind sio_orient sio_orient_chk #(.POS_W(POS_W), .QUAL_CYCLES(QUAL_CYCLES)) u_chk (
    .clk(clk), .rst_n(rst_n), .enc_a(enc_a), .enc_b(enc_b), .enc_mode_pdir(enc_mode_pdir),
    .index_gate_en(index_gate_en), .lock_gain(lock_gain), .home_offset(home_offset),
    .target_pos(target_pos), .demand_below_thr(demand_below_thr),
    .feedback_below_thr(feedback_below_thr), .lock_active(lock_active),
    .orient_active(orient_active), .pos_error(pos_error), .seek_reverse(seek_reverse),
    .at_target_flag(at_target_flag), .pos_count(pos_count)
);

// file: tb_top.sv
// self-checking bench for the orientation block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mode = 1'b0;
    logic gate = 1'b1;
    logic [15:0] gain = 16'h0;
    logic signed [31:0] hoff = 32'h0;
    logic signed [31:0] tgt = 32'h0;
    logic dbt = 1'b0;
    logic fbt = 1'b0;
    wire a, b, idx, lock, orient, seek, flag;
    wire signed [31:0] perr, pcnt;
    wire [15:0] rate;
    int err_count = 0;
    int compares = 0;
    int seed = 9125;
    logic signed [31:0] cnt = 32'h0;
    logic signed [31:0] ipos;
    logic [31:0] seen;
    logic [2:0] sel_q[$];
    logic [31:0] exp_q[$];
    string nm[8] = '{"count", "flag", "lock", "orient", "error", "seek", "rate", "span"};
    event smp;
    initial forever #50 clk = ~clk;
    sio_enc_model i_enc (.clk(clk), .enc_a(a), .enc_b(b), .idx(idx));
    sio_orient #(.QUAL_CYCLES(20), .RATE_GATE_CYCLES(50)) i_dut (
        .clk(clk), .rst_n(rst_n), .enc_a(a), .enc_b(b), .index_input_terminal(idx),
        .enc_mode_pdir(mode), .index_gate_en(gate), .lock_gain(gain), .home_offset(hoff),
        .target_pos(tgt), .demand_below_thr(dbt), .feedback_below_thr(fbt),
        .lock_active(lock), .orient_active(orient), .pos_error(perr), .seek_reverse(seek),
        .at_target_flag(flag), .pos_count(pcnt), .index_rate_monitor(rate)
    );
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #10;
    endtask
    task automatic ex(input logic [2:0] s, input logic [31:0] v);
        sel_q.push_back(s);
        exp_q.push_back(v);
        -> smp;
        #1;
    endtask
    task automatic check(input logic [2:0] s, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm[s], exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(smp)
    begin
        case (sel_q[0])
            3'h0: seen = pcnt;
            3'h1: seen = {31'h0, flag};
            3'h2: seen = {31'h0, lock};
            3'h3: seen = {31'h0, orient};
            3'h4: seen = perr;
            3'h5: seen = {31'h0, seek};
            3'h6: seen = {16'h0, rate};
            default: seen = pcnt < 0 ? -pcnt : pcnt;
        endcase
        check(sel_q.pop_front(), seen, exp_q.pop_front());
    end
    initial
    begin
        #2000000;
        err_count++;
        wrap_up();
    end
    initial
    begin
        cyc(3);
        rst_n = 1'b1;
        gain = 16'h1;
        i_enc.go(8, 0, 0);
        cyc(4);
        ex(3'h7, 32'h8);
        i_enc.go(8, 1, 0);
        cyc(4);
        ex(3'h0, 32'h0);
        mode = 1'b1;
        i_enc.go(5, 1, 1);
        cnt = -5 + ($random(seed) & 32'h7);
        i_enc.go(cnt + 5, 0, 1);
        cyc(4);
        ex(3'h0, cnt);
        // orientation with a gated marker
        ipos = cnt;
        i_enc.mark(120);
        i_enc.go(3, 0, 1);
        cnt = cnt + 3;
        hoff = 32'h6;
        tgt = ($random(seed) & 32'h7) + 1;
        dbt = 1'b1;
        fbt = 1'b1;
        cyc(10);
        ex(3'h2, 32'h0);
        cyc(15);
        ex(3'h2, 32'h1);
        ex(3'h3, 32'h1);
        ex(3'h5, 32'h0);
        ex(3'h4, ipos + hoff + tgt - cnt);
        i_enc.go(ipos + hoff + tgt - cnt, 0, 1);
        cnt = ipos + hoff + tgt;
        cyc(4);
        ex(3'h1, 32'h1);
        fbt = 1'b0;
        tgt = tgt + 3;
        cyc(4);
        ex(3'h1, 32'h0);
        ex(3'h2, 32'h1);
        i_enc.go(3, 0, 1);
        cnt = cnt + 3;
        hoff = 32'h9;
        cyc(4);
        ex(3'h1, 32'h1);
        ex(3'h4, 32'h0);
        dbt = 1'b0;
        cyc(4);
        ex(3'h2, 32'h0);
        tgt = tgt + 2;
        cyc(2);
        ex(3'h4, 32'h0);
        // gated-off and too short markers are refused
        gate = 1'b0;
        i_enc.mark(120);
        cyc(100);
        ex(3'h6, 32'h0);
        gate = 1'b1;
        ipos = cnt;
        i_enc.mark(120);
        i_enc.go(2, 0, 1);
        cnt = cnt + 2;
        i_enc.mark(50);
        i_enc.go(2, 0, 1);
        cnt = cnt + 2;
        hoff = -32'sh6;
        tgt = 32'h5;
        dbt = 1'b1;
        fbt = 1'b1;
        cyc(25);
        ex(3'h5, 32'h1);
        ex(3'h4, ipos + hoff + tgt - cnt);
        // lock without marker reference
        dbt = 1'b0;
        cyc(4);
        gate = 1'b0;
        dbt = 1'b1;
        cyc(25);
        ex(3'h2, 32'h1);
        ex(3'h3, 32'h0);
        i_enc.go(2, 0, 1);
        cyc(4);
        ex(3'h4, -32'sh2);
        wrap_up();
    end
endmodule
